// ==== hw/fsw_guard_check.sv ====
// combinational verdict on one flash command: allowed or refused
// assumes the caller holds address and operation stable while it reads the verdict
`timescale 1ns/1ps
module fsw_guard_check (
  input  wire logic [19:0] flash_addr,
  input  wire logic [1:0]  flash_op,
  input  wire logic        self_prog,
  input  wire logic        ext_prog,
  input  wire logic [7:0]  win_start,
  input  wire logic [7:0]  win_end,
  input  wire logic        boot_protect,
  input  wire logic        sec_erase_dis,
  input  wire logic        sec_write_dis,
  output logic             allow
);

  // ==========================================================
  // area and window decode
  logic       is_code;
  logic       is_data;
  logic       is_modify;
  logic [7:0] blk;
  logic       in_win;
  logic       win_block;
  logic       boot_block;
  logic       sec_block;

  assign is_code   = fsw_pkg::in_range(flash_addr, fsw_pkg::CF_FIRST, fsw_pkg::CF_LAST);
  assign is_data   = fsw_pkg::in_range(flash_addr, fsw_pkg::DF_FIRST, fsw_pkg::DF_LAST);
  assign is_modify = (flash_op == fsw_pkg::OP_WRITE) || (flash_op == fsw_pkg::OP_ERASE);
  assign blk       = fsw_pkg::block_of(flash_addr);
  assign in_win    = (blk >= win_start) && (blk <= win_end);

  // window only guards code flash while self-programming, never external programming
  assign win_block  = self_prog && !ext_prog && is_code && !in_win;
  assign boot_block = boot_protect && fsw_pkg::in_range(flash_addr, fsw_pkg::CF_FIRST, fsw_pkg::BOOT_LAST);
  // programmer security bits reach only the external path
  assign sec_block  = ext_prog && (((flash_op == fsw_pkg::OP_ERASE) && sec_erase_dis) ||
                                   ((flash_op == fsw_pkg::OP_WRITE) && sec_write_dis));

  // speed mode takes no part: verify and modify pass alike in both modes
  assign allow = (self_prog || ext_prog) && (is_code || is_data) && (flash_op != fsw_pkg::OP_NONE) &&
                 (!is_modify || !(win_block || boot_block || sec_block));

endmodule

// ==== hw/fsw_window_guard.sv ====
// apb-controlled guard between the self-programming core and the flash sequencer
// assumes the sequencer runs on pclk and answers each fl_req with a one-cycle fl_done
//
// Functional notes
// - self-programming write or erase outside the window is refused.
// - window spans start block through end block inclusive.
// - window settings change only while external programming mode is active.
// - external programming ignores the window entirely.
// - window guards code flash only; data flash is never window-checked.
// - full-speed mode only when both speed-select option bits are one.
// - voltage argument 00h selects full speed, anything else wide voltage.
// - write, erase and verify work the same in both modes.
// - boot protection refuses boot region erase and write, self-programming too.
// - external security prohibitions do not block self-programming requests.
`timescale 1ns/1ps
module fsw_window_guard (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_prog_mode,
  input  wire logic        flash_speed_select_hi,
  input  wire logic        flash_speed_select_lo,
  input  wire logic        boot_protect,
  input  wire logic        sec_erase_dis,
  input  wire logic        sec_write_dis,
  input  wire logic        hs_osc_halt,
  input  wire logic        fl_done,
  input  wire logic        fl_err,
  output logic             fl_req,
  output logic      [1:0]  fl_op,
  output logic      [19:0] fl_addr,
  output logic             self_prog_active,
  output logic             full_speed_mode
);

  // ==========================================================
  // pin synchronisers
  logic [6:0]  pin_meta;
  logic [6:0]  pin_sync;
  logic [6:0]  pin_raw;
  logic        ext_s;

  assign pin_raw = {hs_osc_halt, sec_write_dis, sec_erase_dis, boot_protect,
                    flash_speed_select_lo, flash_speed_select_hi, ext_prog_mode};
  assign ext_s   = pin_sync[fsw_pkg::PIN_EXT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 7'h00;
      pin_sync <= 7'h00;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  // ==========================================================
  // apb decode: one wait state, writes land on the edge where pready is seen
  fsw_pkg::fsw_state_e state;
  fsw_pkg::fsw_state_e next_state;
  logic        acc;
  logic        wr_fire;
  logic        sel_ctrl;
  logic        sel_win;
  logic        sel_init;
  logic        sel_cmd;
  logic        sel_stat;
  logic        mapped;
  logic        bad_wr;
  logic        busy;
  logic [31:0] rd_data;
  logic [8:0]  stat_word;

  assign acc      = psel && penable;
  assign wr_fire  = acc && pready && pwrite;
  assign sel_ctrl = (paddr == fsw_pkg::OFS_CTRL);
  assign sel_win  = (paddr == fsw_pkg::OFS_WIN);
  assign sel_init = (paddr == fsw_pkg::OFS_INIT);
  assign sel_cmd  = (paddr == fsw_pkg::OFS_CMD);
  assign sel_stat = (paddr == fsw_pkg::OFS_STAT);
  assign mapped   = sel_ctrl || sel_win || sel_init || sel_cmd || sel_stat;
  assign busy     = (state != fsw_pkg::FSW_IDLE);
  // a window write from the self-programming side is refused with an error
  assign bad_wr   = pwrite && ((sel_win && !ext_s) || (sel_cmd && busy));

  // ==========================================================
  // configuration registers
  logic        self_prog;
  logic [7:0]  win_start;
  logic [7:0]  win_end;
  logic        full_speed;
  logic [19:0] cmd_addr;
  logic [1:0]  cmd_op;
  logic        done;
  logic        refused;
  logic        seq_err;
  logic        mode_err;
  logic        allow;
  logic        both_sel;
  logic [7:0]  varg;
  logic        init_wr;
  logic        cmd_go;
  logic        refuse_now;
  logic        finish_now;

  assign both_sel   = pin_sync[fsw_pkg::PIN_SEL_HI] && pin_sync[fsw_pkg::PIN_SEL_LO];
  assign varg       = pwdata[fsw_pkg::VARG_W-1:0];
  assign init_wr    = wr_fire && sel_init;
  assign cmd_go     = wr_fire && sel_cmd && !busy;
  assign refuse_now = (state == fsw_pkg::FSW_CHECK) && !allow;
  assign finish_now = (state == fsw_pkg::FSW_RUN) && fl_done;

  // external mode always wins over the self-programming enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      self_prog <= 1'b0;
    end else if (ext_s) begin
      self_prog <= 1'b0;
    end else if (wr_fire && sel_ctrl) begin
      self_prog <= pwdata[fsw_pkg::CTRL_SELF];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_start <= fsw_pkg::WIN_START_RST;
      win_end   <= fsw_pkg::WIN_END_RST;
    end else if (wr_fire && sel_win && ext_s) begin
      win_start <= pwdata[fsw_pkg::WIN_START_LSB +: fsw_pkg::BLK_W];
      win_end   <= pwdata[fsw_pkg::WIN_END_LSB +: fsw_pkg::BLK_W];
    end
  end

  // full speed is granted only with both option bits set; asking for it without them gives wide voltage and a flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_speed <= 1'b0;
    end else if (init_wr) begin
      full_speed <= (varg == fsw_pkg::VOLT_FULL) && both_sel;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_addr <= 20'h00000;
      cmd_op   <= fsw_pkg::OP_NONE;
    end else if (cmd_go) begin
      cmd_addr <= pwdata[fsw_pkg::FA_W-1:0];
      cmd_op   <= pwdata[fsw_pkg::CMD_OP_LSB +: 2];
    end
  end

  // ==========================================================
  // sticky status: write one to clear, a same-cycle set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done     <= 1'b0;
      refused  <= 1'b0;
      seq_err  <= 1'b0;
      mode_err <= 1'b0;
    end else begin
      done     <= (done && !(wr_fire && sel_stat && pwdata[fsw_pkg::ST_DONE])) || refuse_now || finish_now;
      refused  <= (refused && !(wr_fire && sel_stat && pwdata[fsw_pkg::ST_REFUSED])) || refuse_now;
      seq_err  <= (seq_err && !(wr_fire && sel_stat && pwdata[fsw_pkg::ST_SEQ_ERR])) || (finish_now && fl_err);
      mode_err <= (mode_err && !(wr_fire && sel_stat && pwdata[fsw_pkg::ST_MODE_ERR])) ||
                  (init_wr && (varg == fsw_pkg::VOLT_FULL) && !both_sel);
    end
  end

  // ==========================================================
  // command sequencing
  fsw_guard_check u_check (
    .flash_addr    (cmd_addr),
    .flash_op      (cmd_op),
    .self_prog     (self_prog),
    .ext_prog      (ext_s),
    .win_start     (win_start),
    .win_end       (win_end),
    .boot_protect  (pin_sync[fsw_pkg::PIN_BOOT]),
    .sec_erase_dis (pin_sync[fsw_pkg::PIN_SEC_ERASE]),
    .sec_write_dis (pin_sync[fsw_pkg::PIN_SEC_WRITE]),
    .allow         (allow)
  );

  always_comb begin
    next_state = state;
    unique case (state)
      fsw_pkg::FSW_IDLE:  if (cmd_go) next_state = fsw_pkg::FSW_CHECK;
      fsw_pkg::FSW_CHECK: next_state = allow ? fsw_pkg::FSW_RUN : fsw_pkg::FSW_IDLE;
      fsw_pkg::FSW_RUN:   if (fl_done) next_state = fsw_pkg::FSW_IDLE;
      default:            next_state = fsw_pkg::FSW_IDLE;
    endcase
  end

  // a refused command never raises fl_req, so the array stays untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= fsw_pkg::FSW_IDLE;
      fl_req  <= 1'b0;
      fl_op   <= fsw_pkg::OP_NONE;
      fl_addr <= 20'h00000;
    end else begin
      state   <= next_state;
      fl_req  <= ((state == fsw_pkg::FSW_CHECK) && allow) || (fl_req && !fl_done);
      fl_op   <= ((state == fsw_pkg::FSW_CHECK) && allow) ? cmd_op : fl_op;
      fl_addr <= ((state == fsw_pkg::FSW_CHECK) && allow) ? cmd_addr : fl_addr;
    end
  end

  // ==========================================================
  // read mux and apb answer
  assign stat_word = {pin_sync[fsw_pkg::PIN_OSC_HALT], ext_s, self_prog, mode_err, full_speed,
                      seq_err, refused, done, busy};
  assign rd_data   = sel_ctrl ? {31'h00000000, self_prog} :
                     sel_win  ? {16'h0000, win_end, win_start} :
                     sel_init ? {31'h00000000, full_speed} :
                     sel_cmd  ? {10'h000, cmd_op, cmd_addr} :
                     sel_stat ? {23'h000000, stat_word} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready           <= 1'b0;
      pslverr          <= 1'b0;
      prdata           <= 32'h00000000;
      self_prog_active <= 1'b0;
      full_speed_mode  <= 1'b0;
    end else begin
      pready           <= acc && !pready;
      pslverr          <= acc && !pready && (!mapped || bad_wr);
      prdata           <= (acc && !pready && !pwrite) ? rd_data : 32'h00000000;
      self_prog_active <= self_prog;
      full_speed_mode  <= full_speed;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [7:0] cmd_blk;
  logic       cmd_code;
  logic       cmd_mod;
  assign cmd_blk  = fsw_pkg::block_of(cmd_addr);
  assign cmd_code = fsw_pkg::in_range(cmd_addr, fsw_pkg::CF_FIRST, fsw_pkg::CF_LAST);
  assign cmd_mod  = (cmd_op == fsw_pkg::OP_WRITE) || (cmd_op == fsw_pkg::OP_ERASE);

  sequence s_checking;
    state == fsw_pkg::FSW_CHECK;
  endsequence
  sequence s_issued;
    fl_req && (fl_addr == $past(cmd_addr));
  endsequence
  sequence s_refused;
    !fl_req && refused && done && (state == fsw_pkg::FSW_IDLE);
  endsequence

  a_out_window_refused: assert property ((s_checking and (self_prog && !ext_s && cmd_code && cmd_mod &&
      (cmd_blk < win_start || cmd_blk > win_end))) |=> s_refused) else $error("write outside window issued");
  a_window_inclusive: assert property ($rose(fl_req) && $past(self_prog && !ext_s && cmd_code && cmd_mod) |->
      (fsw_pkg::block_of(fl_addr) >= win_start) && (fsw_pkg::block_of(fl_addr) <= win_end))
      else $error("issued block lies outside window");
  a_window_locked: assert property (($changed(win_start) || $changed(win_end)) |-> $past(ext_s))
      else $error("window changed outside external mode");
  a_ext_no_window: assert property ((s_checking and (ext_s && cmd_code && cmd_mod && cmd_blk > win_end &&
      !pin_sync[fsw_pkg::PIN_BOOT] && !pin_sync[fsw_pkg::PIN_SEC_ERASE] && !pin_sync[fsw_pkg::PIN_SEC_WRITE]))
      |=> s_issued) else $error("external command blocked by window");
  a_data_unguarded: assert property ((s_checking and (self_prog &&
      fsw_pkg::in_range(cmd_addr, fsw_pkg::DF_FIRST, fsw_pkg::DF_LAST) && cmd_op != fsw_pkg::OP_NONE))
      |=> s_issued) else $error("data flash command blocked");
  a_full_needs_bits: assert property (init_wr && !both_sel && (varg == fsw_pkg::VOLT_FULL) |=>
      !full_speed && mode_err ##1 !full_speed_mode) else $error("full speed granted without option bits");
  a_mode_select: assert property (init_wr |=> full_speed == ($past(varg) == fsw_pkg::VOLT_FULL && $past(both_sel)))
      else $error("voltage argument decoded wrongly");
  a_verify_free: assert property ((s_checking and (self_prog && cmd_code && cmd_op == fsw_pkg::OP_VERIFY))
      |=> s_issued) else $error("verify refused");
  a_boot_guard: assert property ($rose(fl_req) && pin_sync[fsw_pkg::PIN_BOOT] && (fl_op != fsw_pkg::OP_VERIFY)
      |-> fl_addr > fsw_pkg::BOOT_LAST) else $error("boot region modified");
  a_sec_bypassed: assert property ((s_checking and (self_prog && !ext_s && cmd_code && cmd_mod &&
      cmd_blk >= win_start && cmd_blk <= win_end && cmd_addr > fsw_pkg::BOOT_LAST)) |=> s_issued)
      else $error("self command blocked by security bits");
  a_refuse_status: assert property (s_checking ##0 !allow |=> s_refused ##1 !fl_req)
      else $error("refused command left no status");

endmodule

// ==== pkg/fsw_pkg.sv ====
// constants, register map and state codes for the flash shield window guard
// assumes a 100 MHz apb clock shared by the guard and the flash sequencer
package fsw_pkg;

  // ==========================================================
  // register map, byte addresses on a 12-bit apb window
  localparam int unsigned   ADDR_W    = 12;
  localparam logic [11:0]   OFS_CTRL  = 12'h000;
  localparam logic [11:0]   OFS_WIN   = 12'h004;
  localparam logic [11:0]   OFS_INIT  = 12'h008;
  localparam logic [11:0]   OFS_CMD   = 12'h00c;
  localparam logic [11:0]   OFS_STAT  = 12'h010;

  // ==========================================================
  // field layouts
  localparam int unsigned   CTRL_SELF     = 0;
  localparam int unsigned   BLK_W         = 8;
  localparam int unsigned   WIN_START_LSB = 0;
  localparam int unsigned   WIN_END_LSB   = 8;
  localparam int unsigned   VARG_W        = 8;
  localparam int unsigned   FA_W          = 20;
  localparam int unsigned   CMD_OP_LSB    = 20;
  localparam int unsigned   ST_BUSY       = 0;
  localparam int unsigned   ST_DONE       = 1;
  localparam int unsigned   ST_REFUSED    = 2;
  localparam int unsigned   ST_SEQ_ERR    = 3;
  localparam int unsigned   ST_FULL       = 4;
  localparam int unsigned   ST_MODE_ERR   = 5;
  localparam int unsigned   ST_SELF       = 6;
  localparam int unsigned   ST_EXT        = 7;
  localparam int unsigned   ST_OSC_HALT   = 8;
  localparam int unsigned   ST_W          = 9;

  // ==========================================================
  // reset values and encodings
  localparam logic [7:0]    WIN_START_RST = 8'h00;
  localparam logic [7:0]    WIN_END_RST   = 8'h0f;
  localparam logic [7:0]    VOLT_FULL     = 8'h00;
  localparam logic [1:0]    OP_NONE       = 2'h0;
  localparam logic [1:0]    OP_WRITE      = 2'h1;
  localparam logic [1:0]    OP_ERASE      = 2'h2;
  localparam logic [1:0]    OP_VERIFY     = 2'h3;

  // ==========================================================
  // flash address map
  localparam int unsigned   BLK_SHIFT     = 10;
  localparam logic [19:0]   CF_FIRST      = 20'h00000;
  localparam logic [19:0]   CF_LAST       = 20'h03fff;
  localparam logic [19:0]   BOOT_LAST     = 20'h00fff;
  localparam logic [19:0]   DF_FIRST      = 20'hf1000;
  localparam logic [19:0]   DF_LAST       = 20'hf17ff;

  // ==========================================================
  // synchronised pin vector positions
  localparam int unsigned   PIN_EXT       = 0;
  localparam int unsigned   PIN_SEL_HI    = 1;
  localparam int unsigned   PIN_SEL_LO    = 2;
  localparam int unsigned   PIN_BOOT      = 3;
  localparam int unsigned   PIN_SEC_ERASE = 4;
  localparam int unsigned   PIN_SEC_WRITE = 5;
  localparam int unsigned   PIN_OSC_HALT  = 6;
  localparam int unsigned   PIN_W         = 7;

  typedef enum logic [2:0] {
    FSW_IDLE  = 3'b001,
    FSW_CHECK = 3'b010,
    FSW_RUN   = 3'b100
  } fsw_state_e;

  function automatic logic [7:0] block_of(input logic [19:0] a);
    return 8'(a >> BLK_SHIFT);
  endfunction

  function automatic logic in_range(input logic [19:0] a, input logic [19:0] lo, input logic [19:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

endpackage

// ==== testbench/fsw_window_guard_tb.sv ====
// self-checking bench for the flash shield window guard, apb tasks plus sequencer handshake
// assumes the guard answers apb with one wait state and the bench plays the flash sequencer
`timescale 1ns/1ps
module fsw_window_guard_tb;
  // ==========================================================
  // stimulus and observed signals
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext_prog_mode;
  logic        sel_hi;
  logic        sel_lo;
  logic        boot_protect;
  logic        sec_erase_dis;
  logic        sec_write_dis;
  logic        fl_done;
  logic        fl_err;
  logic        osc_halt;
  logic        fail_next;
  logic        fl_req;
  logic [1:0]  fl_op;
  logic [19:0] fl_addr;
  logic        self_prog_active;
  logic        full_speed_mode;
  logic [31:0] rd;
  logic        er;
  int          err_count;
  int          checked;

  fsw_window_guard fsw_window_guard_i (
    .pclk                  (pclk),
    .presetn               (presetn),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .ext_prog_mode         (ext_prog_mode),
    .flash_speed_select_hi (sel_hi),
    .flash_speed_select_lo (sel_lo),
    .boot_protect          (boot_protect),
    .sec_erase_dis         (sec_erase_dis),
    .sec_write_dis         (sec_write_dis),
    .hs_osc_halt           (osc_halt),
    .fl_done               (fl_done),
    .fl_err                (fl_err),
    .fl_req                (fl_req),
    .fl_op                 (fl_op),
    .fl_addr               (fl_addr),
    .self_prog_active      (self_prog_active),
    .full_speed_mode       (full_speed_mode)
  );

  // ==========================================================
  // clock and helpers
  initial begin
    pclk = 1'b0;
    // pclk clocks both the guard and the bench sequencer, which drives fl_done on pclk edges
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // bounded wait on pready: a hung slave ends the wait instead of the run
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 32'h1, 32'h0);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // pins cross a 2-ff synchroniser, so give them a few edges
  task automatic settle();
    repeat (4) @(posedge pclk);
  endtask

  // one command: expect a sequencer request or a refusal, then status and clear
  task automatic cmd(input logic [19:0] a, input logic [1:0] op, input logic ok);
    int   n;
    logic seen;
    apb(1'b1, fsw_pkg::OFS_CMD, {10'h000, op, a});
    chk("cmd_err", 32'h0, {31'h0, er});
    seen = 1'b0;
    n = 0;
    while (!seen && n < 6) begin
      @(posedge pclk);
      n++;
      if (fl_req === 1'b1) seen = 1'b1;
    end
    chk("fl_req", {31'h0, ok}, {31'h0, seen});
    if (seen) begin
      chk("fl_op", {30'h0, op}, {30'h0, fl_op});
      chk("fl_addr", {12'h000, a}, {12'h000, fl_addr});
      fl_done <= 1'b1;
      fl_err  <= fail_next;
      @(posedge pclk);
      fl_done <= 1'b0;
      fl_err  <= 1'b0;
    end
    apb(1'b0, fsw_pkg::OFS_STAT, 32'h0);
    chk("stat_done", 32'h1, {31'h0, rd[fsw_pkg::ST_DONE]});
    chk("stat_busy", 32'h0, {31'h0, rd[fsw_pkg::ST_BUSY]});
    chk("stat_seq_err", {31'h0, fail_next && seen}, {31'h0, rd[fsw_pkg::ST_SEQ_ERR]});
    chk("stat_refused", {31'h0, !ok}, {31'h0, rd[fsw_pkg::ST_REFUSED]});
    apb(1'b1, fsw_pkg::OFS_STAT, 32'h0000002e);
  endtask

  task automatic conclude();
    $display("counts: %0d checks, %0d mismatches", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #100000;
    err_count++;
    conclude();
  end

  // ==========================================================
  // test sequence
  initial begin
    err_count = 0;
    checked = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ext_prog_mode = 1'b0;
    sel_hi = 1'b0;
    sel_lo = 1'b0;
    boot_protect = 1'b0;
    sec_erase_dis = 1'b0;
    sec_write_dis = 1'b0;
    fl_done = 1'b0;
    fl_err = 1'b0;
    fail_next = 1'b0;
    // fast oscillator kept running while any command is in flight
    osc_halt = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, fsw_pkg::OFS_WIN, 32'h0);
    chk("win_reset", 32'h00000f00, {16'h0, rd[15:0]});
    cmd(20'h01000, fsw_pkg::OP_WRITE, 1'b0);
    $display("test reset done");

    ext_prog_mode <= 1'b1;
    settle();
    apb(1'b1, fsw_pkg::OFS_WIN, 32'h00000604);
    chk("win_wr_err", 32'h0, {31'h0, er});
    apb(1'b0, fsw_pkg::OFS_WIN, 32'h0);
    chk("win_ext", 32'h00000604, {16'h0, rd[15:0]});
    cmd(20'h00000, fsw_pkg::OP_WRITE, 1'b1);
    cmd(20'h03c00, fsw_pkg::OP_ERASE, 1'b1);
    boot_protect <= 1'b1;
    settle();
    cmd(20'h00400, fsw_pkg::OP_ERASE, 1'b0);
    boot_protect <= 1'b0;
    ext_prog_mode <= 1'b0;
    settle();
    $display("test external done");

    apb(1'b1, fsw_pkg::OFS_WIN, 32'h00000a02);
    chk("win_self_err", 32'h1, {31'h0, er});
    apb(1'b0, fsw_pkg::OFS_WIN, 32'h0);
    chk("win_kept", 32'h00000604, {16'h0, rd[15:0]});
    // no interrupt source in this bench, so self-programming runs with interrupts off
    apb(1'b1, fsw_pkg::OFS_CTRL, 32'h1);
    sec_erase_dis <= 1'b1;
    sec_write_dis <= 1'b1;
    settle();
    chk("self_active", 32'h1, {31'h0, self_prog_active});
    cmd(20'h00c00, fsw_pkg::OP_WRITE, 1'b0);
    cmd(20'h01000, fsw_pkg::OP_WRITE, 1'b1);
    cmd(20'h01bfc, fsw_pkg::OP_ERASE, 1'b1);
    cmd(20'h01c00, fsw_pkg::OP_ERASE, 1'b0);
    fail_next = 1'b1;
    cmd(20'hf1000, fsw_pkg::OP_WRITE, 1'b1);
    fail_next = 1'b0;
    cmd(20'h03fff, fsw_pkg::OP_VERIFY, 1'b1);
    cmd(20'h08000, fsw_pkg::OP_WRITE, 1'b0);
    cmd(20'h01000, fsw_pkg::OP_NONE, 1'b0);
    $display("test window done");

    sel_hi <= 1'b1;
    sel_lo <= 1'b1;
    settle();
    apb(1'b1, fsw_pkg::OFS_INIT, {24'h0, fsw_pkg::VOLT_FULL});
    apb(1'b0, fsw_pkg::OFS_INIT, 32'h0);
    chk("init_full", 32'h1, {31'h0, rd[0]});
    chk("full_port", 32'h1, {31'h0, full_speed_mode});
    cmd(20'h01400, fsw_pkg::OP_ERASE, 1'b1);
    cmd(20'h01800, fsw_pkg::OP_VERIFY, 1'b1);
    apb(1'b1, fsw_pkg::OFS_INIT, 32'h00000001);
    apb(1'b0, fsw_pkg::OFS_INIT, 32'h0);
    chk("init_wide", 32'h0, {31'h0, rd[0]});
    sel_lo <= 1'b0;
    settle();
    apb(1'b1, fsw_pkg::OFS_INIT, {24'h0, fsw_pkg::VOLT_FULL});
    apb(1'b0, fsw_pkg::OFS_STAT, 32'h0);
    chk("mode_err", 32'h1, {31'h0, rd[fsw_pkg::ST_MODE_ERR]});
    chk("full_denied", 32'h0, {31'h0, full_speed_mode});
    $display("test mode done");

    osc_halt <= 1'b1;
    settle();
    apb(1'b0, fsw_pkg::OFS_STAT, 32'h0);
    chk("stat_osc", 32'h1, {31'h0, rd[fsw_pkg::ST_OSC_HALT]});
    chk("stat_self", 32'h1, {31'h0, rd[fsw_pkg::ST_SELF]});
    chk("stat_ext", 32'h0, {31'h0, rd[fsw_pkg::ST_EXT]});
    chk("stat_full", 32'h0, {31'h0, rd[fsw_pkg::ST_FULL]});
    osc_halt <= 1'b0;
    $display("test status done");

    // unmapped word at the top of the 12-bit window
    apb(1'b0, 12'hffc, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, er});
    chk("unmapped_data", 32'h0, rd);
    $display("test unmapped done");
    conclude();
  end
endmodule
